// *** dv/brrs_bench.sv ***
// self-checking bench for the reset sequencing link
`timescale 1ns/1ns
module brrs_bench;
	import brrs_pkg::*;
	typedef struct packed {
		brrs_kind_t k;
		logic kp, fm, ge, g;
		logic [3:0] lat;
	} brrs_row_t;
	logic i_mclk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_req = 1'b0, i_keep_enabled = 1'b0, i_fifo_mode = 1'b0, i_gsr_enable = 1'b0;
	logic i_gsr = 1'b0, i_ce = 1'b1, i_we = 1'b0, i_re = 1'b1;
	brrs_kind_t i_kind = BRRS_RK_ASYNC;
	logic [BRRS_AW-1:0] i_waddr = 4'h3, i_raddr = 4'h3;
	logic [BRRS_DW-1:0] i_wdata = 8'h5a;
	logic [BRRS_DW-1:0] o_rdata;
	logic o_busy, o_done, o_empty, o_full;
	int mismatches = 0, compares = 0;
	// lat 0: latency not checked, only bounded
	brrs_row_t rows [6] = '{
		'{BRRS_RK_ASYNC, 1'b0, 1'b0, 1'b1, 1'b0, 4'h4},
		'{BRRS_RK_FIFO, 1'b0, 1'b1, 1'b1, 1'b0, 4'h4},
		'{BRRS_RK_RPTR, 1'b0, 1'b1, 1'b1, 1'b0, 4'h4},
		'{BRRS_RK_SYNC, 1'b0, 1'b0, 1'b0, 1'b0, 4'h2},
		'{BRRS_RK_ASYNC, 1'b1, 1'b0, 1'b1, 1'b0, 4'h0},
		'{BRRS_RK_ASYNC, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0}};
	brrs_if link ();
	brrs_sequencer brrs_sequencer_inst (.i_mclk(i_mclk), .i_resetn(i_resetn),
		.i_req(i_req), .i_kind(i_kind), .i_keep_enabled(i_keep_enabled),
		.i_fifo_mode(i_fifo_mode), .i_gsr_enable(i_gsr_enable), .i_gsr(i_gsr),
		.i_ce(i_ce), .i_we(i_we), .i_re(i_re), .i_waddr(i_waddr), .i_raddr(i_raddr),
		.i_wdata(i_wdata), .o_rdata(o_rdata), .o_busy(o_busy), .o_done(o_done),
		.link(link));
	brrs_memory brrs_memory_inst (.i_mclk(i_mclk), .link(link), .o_empty(o_empty),
		.o_full(o_full));
	brrs_monitor brrs_monitor_inst (.i_mclk(i_mclk), .i_resetn(i_resetn),
		.ce(link.ce), .we(link.we), .re(link.re), .async_reset(link.async_reset),
		.fifo_reset(link.fifo_reset), .read_pointer_reset(link.read_pointer_reset),
		.sync_reset(link.sync_reset), .global_set_reset(link.global_set_reset),
		.gsr_enable(link.gsr_enable), .fifo_mode(link.fifo_mode));
	// ----
	// tasks
	// ----
	initial begin
		forever #5 i_mclk = ~i_mclk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// set/reset request is dropped after two cycles so the release can proceed
	task automatic run(input brrs_row_t r);
		int n;
		logic open_ce;
		n = 0;
		// enables ride through only when kept on or for a plain sync reset
		open_ce = r.kp | ((r.k == BRRS_RK_SYNC) & ~r.ge);
		i_kind = r.k;
		i_keep_enabled = r.kp;
		i_fifo_mode = r.fm;
		i_gsr_enable = r.ge;
		i_gsr = r.g;
		i_req = 1'b1;
		@(posedge i_mclk);
		#1 i_req = 1'b0;
		while (o_done !== 1'b1 && n < 20) begin
			@(posedge i_mclk);
			#1 n++;
			if (n == 2) i_gsr = 1'b0;
			if (n == 1) chk(8'({o_busy, link.ce}), 8'({1'b1, open_ce}));
		end
		if (n >= 20) begin
			mismatches++;
			test_done();
		end
		if (r.lat != 4'h0) chk(8'(n), 8'(r.lat));
		@(posedge i_mclk);
		#1 chk(8'(o_done), 8'h0);
	endtask
	// ----
	// sequence
	// ----
	initial begin
		repeat (16) @(posedge i_mclk);
		#1 i_resetn = 1'b1;
		chk(8'({o_busy, o_done}), 8'h0);
		foreach (rows[i]) begin
			run(rows[i]);
			$display("row %0d done", i);
		end
		i_fifo_mode = 1'b1;
		i_re = 1'b0;
		i_we = 1'b1;
		repeat (BRRS_DEPTH) @(posedge i_mclk);
		#1 i_we = 1'b0;
		chk(8'({o_full, o_empty}), 8'h2);
		i_re = 1'b1;
		@(posedge i_mclk);
		#1 i_re = 1'b0;
		@(posedge i_mclk);
		#1 chk(o_rdata, 8'h5a);
		chk(8'({o_full, o_empty}), 8'h0);
		run('{BRRS_RK_FIFO, 1'b0, 1'b1, 1'b1, 1'b0, 4'h4});
		chk(8'({o_full, o_empty}), 8'h1);
		$display("fifo reset test done");
		// reset dropped in mid-sequence must leave the link idle
		i_fifo_mode = 1'b0;
		i_kind = BRRS_RK_ASYNC;
		i_req = 1'b1;
		@(posedge i_mclk);
		#1 i_req = 1'b0;
		@(posedge i_mclk);
		#1 i_resetn = 1'b0;
		@(posedge i_mclk);
		#1 chk(8'({o_busy, o_done, link.ce, link.async_reset}), 8'h2);
		i_resetn = 1'b1;
		run(rows[0]);
		$display("mid-run reset test done");
		test_done();
	end
endmodule

// *** dv/brrs_monitor.sv ***
// checker for the sequencer to memory link
`timescale 1ns/1ns
module brrs_monitor (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic ce,
	input wire logic we,
	input wire logic re,
	input wire logic async_reset,
	input wire logic fifo_reset,
	input wire logic read_pointer_reset,
	input wire logic sync_reset,
	input wire logic global_set_reset,
	input wire logic gsr_enable,
	input wire logic fifo_mode
);
	// ----
	// link rules
	// ----
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	a_gate_before_rst: assert property ($rose(async_reset) && !ce |-> !$past(ce))
		else $error("enable not low before reset");
	a_gate_after_rel: assert property ($fell(async_reset) && !ce |=> !ce)
		else $error("enable back too early");
	a_gsr_gated: assert property ($rose(global_set_reset) && !ce |-> !$past(ce))
		else $error("enable not low before set/reset");
	a_fifo_rst_gate: assert property ($rose(fifo_reset) && !we |-> !re && !$past(re))
		else $error("read enable not low before fifo reset");
	a_fifo_rel_gate: assert property ($fell(fifo_reset) && !we |=> !we && !re)
		else $error("fifo enables back too early");
	a_rptr_gate: assert property ($rose(read_pointer_reset) && !re |-> !$past(re))
		else $error("read enable not low before pointer reset");
	a_fifo_gsr_on: assert property (fifo_mode |-> gsr_enable)
		else $error("set/reset not enabled in fifo mode");
	// sync reset without set/reset needs no gating, so enables ride through
	a_sync_no_gate: assert property ($rose(sync_reset) && !gsr_enable |-> $stable(ce))
		else $error("enable disturbed by sync reset");
endmodule

// *** pkg/brrs_if.sv ***
// link between the reset sequencer and the block memory
`timescale 1ns/1ns
interface brrs_if;
	import brrs_pkg::*;
	logic ce;
	logic we;
	logic re;
	logic [BRRS_AW-1:0] waddr;
	logic [BRRS_AW-1:0] raddr;
	logic [BRRS_DW-1:0] wdata;
	logic [BRRS_DW-1:0] rdata;
	logic async_reset;
	logic fifo_reset;
	logic read_pointer_reset;
	logic sync_reset;
	logic global_set_reset;
	logic gsr_enable;
	logic fifo_mode;
	modport seq (output ce, output we, output re, output waddr, output raddr,
		output wdata, input rdata, output async_reset, output fifo_reset,
		output read_pointer_reset, output sync_reset, output global_set_reset,
		output gsr_enable, output fifo_mode);
	modport mem (input ce, input we, input re, input waddr, input raddr,
		input wdata, output rdata, input async_reset, input fifo_reset,
		input read_pointer_reset, input sync_reset, input global_set_reset,
		input gsr_enable, input fifo_mode);
endinterface

// *** pkg/brrs_pkg.sv ***
// shared constants and types for the block memory reset sequencing link
package brrs_pkg;
	localparam int BRRS_AW = 4;
	localparam int BRRS_DW = 8;
	localparam int BRRS_DEPTH = 16;
	// steady-clock guard: one max-frequency period, figure as ns
	localparam int BRRS_TFMAX_NS = 10;
	localparam int BRRS_CLK_NS = 10;
	localparam int BRRS_GUARD_CYC = (BRRS_TFMAX_NS + BRRS_CLK_NS - 1) / BRRS_CLK_NS;
	localparam logic [1:0] BRRS_GUARD_W = 2'h1;
	localparam logic [1:0] BRRS_CNT_ZERO = 2'h0;
	// reset kinds requested by user logic
	typedef enum logic [1:0] {
		BRRS_RK_ASYNC,
		BRRS_RK_FIFO,
		BRRS_RK_RPTR,
		BRRS_RK_SYNC
	} brrs_kind_t;
	typedef enum logic [2:0] {
		BRRS_S_RUN,
		BRRS_S_GATE,
		BRRS_S_RESET,
		BRRS_S_HOLD,
		BRRS_S_DONE
	} brrs_state_t;
endpackage

// *** rtl/brrs_memory.sv ***
// embedded block memory end: ram or fifo with its reset inputs
`timescale 1ns/1ns
module brrs_memory
	import brrs_pkg::*;
(
	input wire logic i_mclk,
	brrs_if.mem link,
	output logic o_empty,
	output logic o_full
);
	// -------------------------------------------------
	// storage and pointers
	// -------------------------------------------------
	logic [BRRS_DW-1:0] mem [BRRS_DEPTH];
	logic [BRRS_AW:0] wptr;
	logic [BRRS_AW:0] rptr;
	logic [BRRS_AW:0] next_wptr;
	logic [BRRS_AW:0] next_rptr;
	logic [BRRS_DW-1:0] rdata;
	logic [BRRS_DW-1:0] next_rdata;
	logic gsr_hit;
	logic full_rst;
	logic do_wr;
	logic do_rd;
	logic rptr_rst;

	// global set/reset acts without a clock, fifo mode keeps it on
	assign gsr_hit = link.global_set_reset & (link.gsr_enable | link.fifo_mode);
	assign full_rst = gsr_hit | link.async_reset | (link.fifo_mode & link.fifo_reset);
	assign o_empty = (wptr == rptr);
	assign o_full = (wptr[BRRS_AW] != rptr[BRRS_AW]) &&
		(wptr[BRRS_AW-1:0] == rptr[BRRS_AW-1:0]);
	// in fifo mode the enables stand in for the clock enable
	assign do_wr = link.fifo_mode ? (link.we & ~o_full) : (link.ce & link.we);
	assign do_rd = link.fifo_mode ? (link.re & ~o_empty) : link.ce;
	assign link.rdata = rdata;

	// -------------------------------------------------
	// next values
	// -------------------------------------------------
	always_comb begin
		next_wptr = wptr;
		next_rptr = rptr;
		next_rdata = rdata;
		if (link.sync_reset) begin
			// synchronous reset needs no enable ordering
			next_wptr = '0;
			next_rptr = '0;
			next_rdata = '0;
		end else begin
			if (do_wr && link.fifo_mode) begin
				next_wptr = wptr + 1'b1;
			end
			if (do_rd) begin
				if (link.fifo_mode) begin
					next_rdata = mem[rptr[BRRS_AW-1:0]];
					next_rptr = rptr + 1'b1;
				end else begin
					next_rdata = mem[link.raddr];
				end
			end
		end
	end

	// array holds no reset, only the output latch and pointers do
	always_ff @(posedge i_mclk) begin
		if (do_wr) begin
			mem[link.fifo_mode ? wptr[BRRS_AW-1:0] : link.waddr] <= link.wdata;
		end
	end

	always_ff @(posedge i_mclk or posedge full_rst) begin
		if (full_rst) begin
			wptr <= '0;
			rdata <= '0;
		end else begin
			wptr <= next_wptr;
			rdata <= next_rdata;
		end
	end

	// read pointer has its own asynchronous reset as well
	always_ff @(posedge i_mclk or posedge rptr_rst) begin
		if (rptr_rst) begin
			rptr <= '0;
		end else begin
			rptr <= next_rptr;
		end
	end

	assign rptr_rst = full_rst | (link.fifo_mode & link.read_pointer_reset);
endmodule

// *** rtl/brrs_sequencer.sv ***
// user-side reset sequencer: gates enables around block memory resets
`timescale 1ns/1ns
module brrs_sequencer
	import brrs_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_req,
	input wire brrs_kind_t i_kind,
	input wire logic i_keep_enabled,
	input wire logic i_fifo_mode,
	input wire logic i_gsr_enable,
	input wire logic i_gsr,
	input wire logic i_ce,
	input wire logic i_we,
	input wire logic i_re,
	input wire logic [BRRS_AW-1:0] i_waddr,
	input wire logic [BRRS_AW-1:0] i_raddr,
	input wire logic [BRRS_DW-1:0] i_wdata,
	output logic [BRRS_DW-1:0] o_rdata,
	output logic o_busy,
	output logic o_done,
	brrs_if.seq link
);
	// -------------------------------------------------
	// sequencer state
	// -------------------------------------------------
	brrs_state_t state;
	brrs_state_t next_state;
	brrs_kind_t kind;
	brrs_kind_t next_kind;
	logic [1:0] cnt;
	logic [1:0] next_cnt;
	logic gate_w;
	logic next_gate_w;
	logic gate_r;
	logic next_gate_r;
	logic rst_on;
	logic next_rst_on;
	logic gsr_q;
	logic next_gsr_q;
	logic [BRRS_DW-1:0] rdata;
	logic done;
	logic next_done;

	// which enables a reset kind must gate
	function automatic logic gates_write(input brrs_kind_t k);
		return (k == BRRS_RK_ASYNC) || (k == BRRS_RK_FIFO);
	endfunction

	always_comb begin
		next_state = state;
		next_kind = kind;
		next_cnt = cnt;
		next_gate_w = gate_w;
		next_gate_r = gate_r;
		next_rst_on = rst_on;
		next_done = 1'b0;
		// registered gsr; only passes in the RESET state, after the GATE cycle
		next_gsr_q = i_gsr & (i_fifo_mode | i_gsr_enable) & (state == BRRS_S_RESET);
		unique case (state)
			BRRS_S_RUN: begin
				if (i_req) begin
					next_kind = i_kind;
					if (i_kind == BRRS_RK_SYNC && !i_gsr_enable) begin
						// no ordering applies, pulse at once
						next_rst_on = 1'b1;
						next_state = BRRS_S_HOLD;
					end else if (i_keep_enabled) begin
						// clocks run steady one fmax period first
						next_cnt = BRRS_GUARD_W;
						next_state = BRRS_S_GATE;
					end else begin
						next_gate_w = gates_write(i_kind);
						next_gate_r = 1'b1;
						next_cnt = BRRS_GUARD_W;
						next_state = BRRS_S_GATE;
					end
				end
			end
			BRRS_S_GATE: begin
				// one full clock of low enables before reset
				if (cnt != BRRS_CNT_ZERO) begin
					next_cnt = cnt - 1'b1;
				end
				if (cnt == BRRS_GUARD_W) begin
					next_rst_on = 1'b1;
					next_state = BRRS_S_RESET;
				end
			end
			BRRS_S_RESET: begin
				if (!i_gsr) begin
					next_rst_on = 1'b0;
					next_cnt = BRRS_GUARD_W;
					next_state = BRRS_S_HOLD;
				end
			end
			BRRS_S_HOLD: begin
				// keep enables low two cycles after release (here and in DONE)
				next_rst_on = 1'b0;
				next_state = BRRS_S_DONE;
			end
			BRRS_S_DONE: begin
				next_gate_w = 1'b0;
				next_gate_r = 1'b0;
				next_done = 1'b1;
				next_state = BRRS_S_RUN;
			end
			default: begin
				next_state = BRRS_S_RUN;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= BRRS_S_RUN;
			kind <= BRRS_RK_ASYNC;
			cnt <= BRRS_CNT_ZERO;
			gate_w <= 1'b0;
			gate_r <= 1'b0;
			rst_on <= 1'b0;
			gsr_q <= 1'b0;
			done <= 1'b0;
			rdata <= '0;
		end else begin
			state <= next_state;
			kind <= next_kind;
			cnt <= next_cnt;
			gate_w <= next_gate_w;
			gate_r <= next_gate_r;
			rst_on <= next_rst_on;
			gsr_q <= next_gsr_q;
			done <= next_done;
			rdata <= link.rdata;
		end
	end

	// -------------------------------------------------
	// link drive
	// -------------------------------------------------
	// gates from flops keep the spacing exact; only and-gates follow
	assign link.ce = i_ce & ~gate_r & ~gate_w;
	assign link.we = i_we & ~gate_w;
	assign link.re = i_re & ~gate_r;
	assign link.waddr = i_waddr;
	assign link.raddr = i_raddr;
	assign link.wdata = i_wdata;
	assign link.async_reset = rst_on & ~i_fifo_mode & (kind == BRRS_RK_ASYNC);
	assign link.fifo_reset = rst_on & i_fifo_mode & (kind == BRRS_RK_FIFO);
	assign link.read_pointer_reset = rst_on & i_fifo_mode & (kind == BRRS_RK_RPTR);
	assign link.sync_reset = rst_on & (kind == BRRS_RK_SYNC);
	assign link.global_set_reset = gsr_q;
	assign link.gsr_enable = i_gsr_enable | i_fifo_mode;
	assign link.fifo_mode = i_fifo_mode;
	assign o_rdata = rdata;
	assign o_busy = (state != BRRS_S_RUN);
	assign o_done = done;
endmodule
